// ---- hw/adcsq_map.svh ----
// Constants for the converter channel sequencer.
`ifndef ADCSQ_MAP_SVH
`define ADCSQ_MAP_SVH
`define ADCSQ_LEN_ONE        4'h1
`define ADCSQ_LEN_FOUR       4'h4
`define ADCSQ_LEN_EIGHT      4'h8
`define ADCSQ_SPC_REF_HIGH   3'h4
`define ADCSQ_SPC_REF_LOW    3'h5
`define ADCSQ_SPC_REF_MID    3'h6
`define ADCSQ_CODE_REF_HIGH  8'hFF
`define ADCSQ_CODE_REF_LOW   8'h00
`define ADCSQ_CODE_REF_MID   8'h7F
`define ADCSQ_CHAN_RST       3'h0
`define ADCSQ_POS_RST        3'h0
`define ADCSQ_FLAGS_RST      8'h00
`endif

// ---- hw/adcsq_pkg.sv ----
// Types for the converter channel sequencer.
package adcsq_pkg;
  typedef enum logic [1:0] {
    ADCSQ_IDLE,
    ADCSQ_CONV,
    ADCSQ_WAIT
  } adcsq_state_t;
endpackage

// ---- hw/adcsq_sequencer.sv ----
// Channel sequencer of the analog-to-digital converter.
// Notes on behaviour
// - Multi-channel off: every conversion of the sequence uses the coded channel.
// - Multi-channel on: start at coded channel, step by one per conversion.
// - Channel code wraps from its maximum back to its minimum.
// - Special mode off converts external inputs; on converts an internal source.
// - Special codes: 100 high ref, 101 low ref, 110 midpoint; others reserved.
// - At 8-bit resolution high, low, mid give FF, 00, 7F.
// - External code is a binary index selecting one of eight inputs.
// - Four-long scan fills results 0..3 with consecutive channels, wrapping.
// - Eight-long scan fills results 0..7 with consecutive channels, modulo eight.
// - Single-channel mode repeats the one selected channel four or eight times.
// - Eight-bit clear, single-bit set: one conversion of selected channel, repeated while scan_enable_i is high.
// - A control write aborts the running sequence and starts a new one.
// - Length: 00 gives 4, 01 gives 1, 1x gives 8.
// - Result-ready flag n sets when conversion n lands in result n.
`timescale 1ns/10ps
`default_nettype none
`include "adcsq_map.svh"
module adcsq_sequencer #(
  parameter int unsigned NUM_POS = 8
) (
  input  wire logic         core_clk_i,
  input  wire logic         rst_i,
  input  wire logic         ctl_write_i,
  input  wire logic         multi_channel_enable_i,
  input  wire logic         special_channel_enable_i,
  input  wire logic         chan_sel_bit2_i,
  input  wire logic         chan_sel_bit1_i,
  input  wire logic         chan_sel_bit0_i,
  input  wire logic         eight_length_bit_i,
  input  wire logic         single_length_bit_i,
  input  wire logic         scan_enable_i,
  input  wire logic         conv_done_i,
  output logic              conv_start_o,
  output logic              special_sel_o,
  output logic [2:0]        chan_index_o,
  output logic [7:0]        input_select_o,
  output logic [2:0]        special_code_o,
  output logic [7:0]        expected_code_o,
  output logic              special_valid_o,
  output logic [2:0]        result_reg_n_o,
  output logic [NUM_POS-1:0] result_ready_flag_o,
  output logic              sequence_done_flag_o,
  output logic              busy_o
);

  adcsq_pkg::adcsq_state_t state_q;
  logic [2:0] start_code_q;
  logic       multi_channel_enable_q;
  logic       spc_q;
  logic [3:0] len_q;
  logic [3:0] len_d;
  logic [2:0] code_in;
  logic       last_pos;
  logic [2:0] chan_cur;
  logic [7:0] sel_onehot;
  logic       spc_def;
  logic [7:0] exp_code;

  assign code_in = {chan_sel_bit2_i, chan_sel_bit1_i, chan_sel_bit0_i};

  // Length decode; eight wins over the single-length bit.
  always_comb begin
    if (eight_length_bit_i) begin
      len_d = `ADCSQ_LEN_EIGHT;
    end else if (single_length_bit_i) begin
      len_d = `ADCSQ_LEN_ONE;
    end else begin
      len_d = `ADCSQ_LEN_FOUR;
    end
  end

  assign last_pos = ({1'b0, result_reg_n_o} == (len_q - 4'h1));

  // Settings other than scan_enable_i are latched on the write so later pin changes wait for a rewrite.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      start_code_q <= `ADCSQ_CHAN_RST;
      multi_channel_enable_q       <= 1'b0;
      spc_q        <= 1'b0;
      len_q        <= `ADCSQ_LEN_FOUR;
    end else if (ctl_write_i) begin
      start_code_q <= code_in;
      multi_channel_enable_q       <= multi_channel_enable_i;
      spc_q        <= special_channel_enable_i;
      len_q        <= len_d;
    end
  end

  // Sequence state machine; a write overrides everything in flight.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= adcsq_pkg::ADCSQ_IDLE;
    end else if (ctl_write_i) begin
      state_q <= adcsq_pkg::ADCSQ_CONV;
    end else begin
      case (state_q)
        adcsq_pkg::ADCSQ_IDLE: begin
          state_q <= adcsq_pkg::ADCSQ_IDLE;
        end
        adcsq_pkg::ADCSQ_CONV: begin
          state_q <= adcsq_pkg::ADCSQ_WAIT;
        end
        adcsq_pkg::ADCSQ_WAIT: begin
          if (conv_done_i) begin
            if (last_pos && !scan_enable_i) begin
              state_q <= adcsq_pkg::ADCSQ_IDLE;
            end else begin
              state_q <= adcsq_pkg::ADCSQ_CONV;
            end
          end
        end
        default: begin
          state_q <= adcsq_pkg::ADCSQ_IDLE;
        end
      endcase
    end
  end

  // Position counter also names the result register being filled.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      result_reg_n_o <= `ADCSQ_POS_RST;
    end else if (ctl_write_i) begin
      result_reg_n_o <= `ADCSQ_POS_RST;
    end else if (state_q == adcsq_pkg::ADCSQ_WAIT && conv_done_i) begin
      if (last_pos) begin
        result_reg_n_o <= `ADCSQ_POS_RST;
      end else begin
        result_reg_n_o <= result_reg_n_o + 3'h1;
      end
    end
  end

  // Channel counter: natural 3-bit overflow gives the wrap to zero.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      chan_cur <= `ADCSQ_CHAN_RST;
    end else if (ctl_write_i) begin
      chan_cur <= code_in;
    end else if (state_q == adcsq_pkg::ADCSQ_WAIT && conv_done_i) begin
      if (last_pos) begin
        chan_cur <= start_code_q;
      end else if (multi_channel_enable_q) begin
        chan_cur <= chan_cur + 3'h1;
      end else begin
        chan_cur <= start_code_q;
      end
    end
  end

  // Decode of the current channel into a source selection.
  always_comb begin
    sel_onehot = 8'h00;
    spc_def    = 1'b0;
    exp_code   = `ADCSQ_CODE_REF_LOW;
    if (!spc_q) begin
      sel_onehot[chan_cur] = 1'b1;
    end else begin
      case (chan_cur)
        `ADCSQ_SPC_REF_HIGH: begin
          spc_def  = 1'b1;
          exp_code = `ADCSQ_CODE_REF_HIGH;
        end
        `ADCSQ_SPC_REF_LOW: begin
          spc_def  = 1'b1;
          exp_code = `ADCSQ_CODE_REF_LOW;
        end
        `ADCSQ_SPC_REF_MID: begin
          spc_def  = 1'b1;
          exp_code = `ADCSQ_CODE_REF_MID;
        end
        default: begin
          spc_def  = 1'b0;
          exp_code = `ADCSQ_CODE_REF_LOW;
        end
      endcase
    end
  end

  // Registered outputs toward the analog machine.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      conv_start_o    <= 1'b0;
      chan_index_o    <= `ADCSQ_CHAN_RST;
      special_sel_o   <= 1'b0;
      input_select_o  <= 8'h00;
      special_code_o  <= `ADCSQ_CHAN_RST;
      expected_code_o <= `ADCSQ_CODE_REF_LOW;
      special_valid_o <= 1'b0;
      busy_o          <= 1'b0;
    end else begin
      conv_start_o    <= (state_q == adcsq_pkg::ADCSQ_CONV) && !ctl_write_i;
      chan_index_o    <= chan_cur;
      special_sel_o   <= spc_q;
      input_select_o  <= sel_onehot;
      special_code_o  <= spc_q ? chan_cur : `ADCSQ_CHAN_RST;
      expected_code_o <= exp_code;
      special_valid_o <= spc_def;
      busy_o          <= ctl_write_i || (state_q != adcsq_pkg::ADCSQ_IDLE);
    end
  end

  // Flags: a control write clears them; a done in the same cycle is dropped
  // because that conversion belonged to the aborted sequence.
  generate
    for (genvar i = 0; i < NUM_POS; i++) begin : g_flag
      always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
          result_ready_flag_o[i] <= 1'b0;
        end else if (ctl_write_i) begin
          result_ready_flag_o[i] <= 1'b0;
        end else if (state_q == adcsq_pkg::ADCSQ_WAIT && conv_done_i &&
                     result_reg_n_o == 3'(i)) begin
          result_ready_flag_o[i] <= 1'b1;
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sequence_done_flag_o <= 1'b0;
    end else if (ctl_write_i) begin
      sequence_done_flag_o <= 1'b0;
    end else if (state_q == adcsq_pkg::ADCSQ_WAIT && conv_done_i && last_pos) begin
      sequence_done_flag_o <= 1'b1;
    end
  end

  AST_WRITE_STARTS: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ctl_write_i ##1 !ctl_write_i |=> conv_start_o && result_reg_n_o == 3'h0)
    else $error("Control write did not start a fresh sequence.");

  AST_FIRST_CHAN: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ctl_write_i |=> chan_cur == $past(code_in))
    else $error("Channel counter not loaded from code.");

  AST_MULTI_STEP: assert property (@(posedge core_clk_i) disable iff (rst_i)
    state_q == adcsq_pkg::ADCSQ_WAIT && conv_done_i && multi_channel_enable_q && !last_pos && !ctl_write_i
    |=> chan_cur == $past(chan_cur) + 3'h1)
    else $error("Multi-channel step did not advance modulo eight.");

  AST_SINGLE_HOLD: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !multi_channel_enable_q && !ctl_write_i && state_q != adcsq_pkg::ADCSQ_IDLE |-> chan_cur == start_code_q)
    else $error("Single-channel sequence changed channel.");

  AST_LEN_DECODE: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ctl_write_i && !eight_length_bit_i && !single_length_bit_i |=> len_q == 4'h4)
    else $error("Length decode wrong for four conversions.");

  AST_LEN_ONE: assert property (@(posedge core_clk_i) disable iff (rst_i)
    len_q == 4'h1 |-> result_reg_n_o == 3'h0)
    else $error("Single-conversion sequence moved past position zero.");

  AST_FLAG_SET: assert property (@(posedge core_clk_i) disable iff (rst_i)
    state_q == adcsq_pkg::ADCSQ_WAIT && conv_done_i && !ctl_write_i
    |=> result_ready_flag_o[$past(result_reg_n_o)])
    else $error("Result-ready flag not set for finished position.");

  AST_SPECIAL_CODE: assert property (@(posedge core_clk_i) disable iff (rst_i)
    spc_q && chan_cur == 3'h6 |=> expected_code_o == 8'h7F && special_valid_o)
    else $error("Midpoint special channel gave wrong expected code.");

  AST_EXT_SELECT: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !spc_q |=> input_select_o == (8'h01 << $past(chan_cur)))
    else $error("External input select does not match channel index.");

  AST_FLAG_CLEAR: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ctl_write_i |=> result_ready_flag_o == '0 && !sequence_done_flag_o)
    else $error("Control write did not clear the completion flags.");

  AST_POS_STEP: assert property (@(posedge core_clk_i) disable iff (rst_i)
    state_q == adcsq_pkg::ADCSQ_WAIT && conv_done_i && !ctl_write_i && !last_pos
    |=> result_reg_n_o == $past(result_reg_n_o) + 3'h1)
    else $error("Result position did not advance by one.");

  AST_LEN_EIGHT: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ctl_write_i && eight_length_bit_i |=> len_q == 4'h8)
    else $error("Length decode wrong for eight conversions.");

  AST_LEN_SINGLE: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ctl_write_i && !eight_length_bit_i && single_length_bit_i |=> len_q == 4'h1)
    else $error("Length decode wrong for one conversion.");

  AST_SPC_HIGH: assert property (@(posedge core_clk_i) disable iff (rst_i)
    spc_q && chan_cur == 3'h4 |=> expected_code_o == 8'hFF && special_valid_o)
    else $error("High reference special channel gave wrong expected code.");

  AST_SPC_LOW: assert property (@(posedge core_clk_i) disable iff (rst_i)
    spc_q && chan_cur == 3'h5 |=> expected_code_o == 8'h00 && special_valid_o)
    else $error("Low reference special channel gave wrong expected code.");

  AST_SPC_RESERVED: assert property (@(posedge core_clk_i) disable iff (rst_i)
    spc_q && (!chan_cur[2] || chan_cur == 3'h7) |=> !special_valid_o && input_select_o == 8'h00)
    else $error("Reserved special code was treated as a defined source.");

endmodule
`default_nettype wire

// ---- test/adcsq_analog_model.sv ----
// Behavioural analog machine that answers each start pulse with a done pulse.
`timescale 1ns/10ps
`default_nettype none
module adcsq_analog_model (
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  input  wire logic       abort_i,
  input  wire logic [3:0] delay_i,
  input  wire logic       start_i,
  output logic            done_o
);
  logic [3:0] cnt_q;
  // A control write aborts the conversion too, so no stale done reaches the next sequence.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= 4'h0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (abort_i) begin
        cnt_q <= 4'h0;
      end else if (start_i) begin
        cnt_q <= delay_i;
      end else if (cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
        done_o <= (cnt_q == 4'h1);
      end
    end
  end
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
// Self-checking bench for the converter channel sequencer.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  typedef struct {
    logic [2:0] ch;
    logic [2:0] pos;
    logic [7:0] isel;
    logic [7:0] ecode;
    logic       spc;
    logic       valid;
  } adcsq_exp_t;
  logic       core_clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       wr, multi_channel_enable, spc, l8, l1, scan, done, start, ssel, valid, sdone, busy;
  logic [2:0] code, chan, scode, rn;
  logic [3:0] dly;
  logic [7:0] isel, ecode, rdy;
  logic [31:0] r;
  int         n_errors = 0;
  int         checked = 0;
  int         k;
  adcsq_exp_t expq[$];
  adcsq_exp_t last, mx;

  always #10 core_clk_i = ~core_clk_i;

  adcsq_sequencer #(.NUM_POS(8)) dut (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .ctl_write_i(wr),
    .multi_channel_enable_i(multi_channel_enable), .special_channel_enable_i(spc),
    .chan_sel_bit2_i(code[2]), .chan_sel_bit1_i(code[1]), .chan_sel_bit0_i(code[0]),
    .eight_length_bit_i(l8), .single_length_bit_i(l1), .scan_enable_i(scan),
    .conv_done_i(done), .conv_start_o(start), .special_sel_o(ssel), .chan_index_o(chan),
    .input_select_o(isel), .special_code_o(scode), .expected_code_o(ecode),
    .special_valid_o(valid), .result_reg_n_o(rn), .result_ready_flag_o(rdy),
    .sequence_done_flag_o(sdone), .busy_o(busy));

  adcsq_analog_model model (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .abort_i(wr), .delay_i(dly),
    .start_i(start), .done_o(done));

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic finish_test;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Each start pulse is matched against the oldest expected conversion.
  // Sampling on the falling edge keeps the check clear of the launching edge.
  always @(negedge core_clk_i) begin
    if (start === 1'b1) begin
      if (expq.size() == 0) begin
        chk("unexpected_start", 8'h00, 8'h01);
      end else begin
        mx = expq.pop_front();
        chk("chan", mx.ch, chan);
        chk("input_sel", mx.isel, isel);
        chk("special_sel", mx.spc, ssel);
        chk("special_code", mx.spc ? mx.ch : 3'h0, scode);
        chk("special_valid", mx.valid, valid);
        chk("expected_code", mx.ecode, ecode);
        chk("result_reg", mx.pos, rn);
        chk("busy", 8'h01, busy);
      end
    end
  end

  task automatic wait_idle(input int nflags);
    int i;
    for (i = 0; i < 600 && (busy !== 1'b0 || expq.size() != 0); i++) begin
      @(negedge core_clk_i);
    end
    chk("wait_ok", 8'h01, 8'(i < 600));
    chk("ready_flags", 8'((9'h1 << nflags) - 9'h1), rdy);
    chk("seq_done", 8'h01, sdone);
  endtask

  // With ab set the task returns after the sequence's first start pulse and drops the expected conversions left for it.
  task automatic run_seq(input logic m, s, input logic [2:0] c, input logic e, o, ab);
    int n;
    int i;
    n = e ? 8 : (o ? 1 : 4);
    for (i = 0; i < n; i++) begin
      last.ch = m ? c + 3'(i) : c;
      last.pos = 3'(i);
      last.spc = s;
      last.isel = s ? 8'h00 : 8'h01 << last.ch;
      last.valid = s && last.ch inside {3'h4, 3'h5, 3'h6};
      last.ecode = !last.valid ? 8'h00 : last.ch == 3'h4 ? 8'hFF : last.ch == 3'h6 ? 8'h7F : 8'h00;
      expq.push_back(last);
    end
    @(posedge core_clk_i);
    dly <= 4'($urandom_range(4, 1));
    {wr, multi_channel_enable, spc, code, l8, l1} <= {1'b1, m, s, c, e, o};
    @(posedge core_clk_i);
    wr <= 1'b0;
    if (ab) begin
      for (i = 0; i < 600 && expq.size() == n; i++) begin
        @(negedge core_clk_i);
      end
      expq.delete();
    end else begin
      wait_idle(n);
    end
  endtask

  initial begin
    void'($urandom(54));
    {wr, multi_channel_enable, spc, l8, l1, scan, code, dly} = '0;
    repeat (12) @(posedge core_clk_i);
    rst_i <= 1'b0;
    run_seq(1'b1, 1'b0, 3'h7, 1'b0, 1'b0, 1'b0);
    run_seq(1'b1, 1'b0, 3'h3, 1'b1, 1'b1, 1'b0);
    run_seq(1'b0, 1'b0, 3'h5, 1'b0, 1'b0, 1'b0);
    run_seq(1'b0, 1'b1, 3'h6, 1'b1, 1'b0, 1'b0);
    for (k = 0; k < 16; k++) begin
      run_seq(1'b0, k[3], k[2:0], 1'b0, 1'b1, 1'b0);
    end
    run_seq(1'b1, 1'b0, 3'h2, 1'b1, 1'b0, 1'b1);
    run_seq(1'b1, 1'b1, 3'h4, 1'b0, 1'b1, 1'b0);
    for (k = 0; k < 6; k++) begin
      r = $urandom;
      run_seq(r[0], 1'b0, r[3:1], r[4], r[5], 1'b0);
    end
    @(posedge core_clk_i);
    scan <= 1'b1;
    run_seq(1'b0, 1'b1, 3'h5, 1'b0, 1'b1, 1'b1);
    expq.push_back(last);
    while (expq.size() != 0) @(negedge core_clk_i);
    @(posedge core_clk_i);
    scan <= 1'b0;
    wait_idle(1);
    finish_test;
  end

  initial begin
    #1_000_000;
    n_errors++;
    finish_test;
  end
endmodule
`default_nettype wire
